// ===== addr_lookup_if.sv
// Address and decode result carried between decoder and region classifier
`timescale 1ns/1ps
interface addr_lookup_if;
    logic [15:0]         addr;
    logic [15:0]         rom_top;
    logic                xram_en;
    memmap_pkg::region_t region;
    logic                in_vec;
    logic                in_table_call_instruction;
    logic                in_fixed_area_call_instruction;
    logic                in_gpr;

    modport requester (output addr, output rom_top, output xram_en,
                       input region, input in_vec, input in_table_call_instruction,
                       input in_fixed_area_call_instruction, input in_gpr);
    modport classifier (input addr, input rom_top, input xram_en,
                        output region, output in_vec, output in_table_call_instruction,
                        output in_fixed_area_call_instruction, output in_gpr);
endinterface

// ===== cpu_memory_map_decoder.sv
// Function
// RL1 - Decode one flat 16-bit, 64 KB space for fetches and data.
// RL2 - Reset loads size select CFH and expansion RAM select 0CH.
// RL3 - Software writes the variant's size and expansion RAM selects.
// RL4 - ROM starts at 0000H; top is 5FFFH, 7FFFH, BFFFH or EFFFH.
// RL5 - 0000H to 003FH is the vector table.
// RL6 - Vectors are little-endian: low byte even, high byte odd.
// RL7 - All reset causes use the vector at 0000H.
// RL8 - Each maskable interrupt reads its own even slot 0004H to 003CH.
// RL9 - 0040H to 007FH holds table call entry addresses.
// RL10 - 0800H to 0FFFH is the fixed-area call target range.
// RL11 - FB00H to FEFFH maps to 1 KB high-speed RAM.
// RL12 - FEE0H to FEFFH holds four banks of eight registers.
// RL13 - High-speed RAM cannot be an instruction fetch area.
// RL14 - High-speed RAM serves as the stack region.
// RL15 - F400H to F7FFH is 1 KB expansion RAM on larger variants.
// RL16 - Expansion RAM allows data access and instruction fetch.
// RL17 - FF00H to FFFFH decodes to peripheral registers.
// RL18 - Software must not touch unassigned peripheral addresses.
// RL19 - Program memory fetched by PC also holds readable table data.
// RL20 - Reset loads PC from the vector at 0000H and 0001H.
`timescale 1ns/1ps
`include "memmap_cfg.svh"
module cpu_memory_map_decoder #(
    parameter int ADDR_W = `ADDR_W
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Size select writes from the CPU
    input  wire logic        size_sel_we,
    input  wire logic        xram_sel_we,
    input  wire logic [7:0]  sel_wdata,
    output logic      [7:0]  memory_size_select,
    output logic      [7:0]  expansion_ram_size_select,
    // CPU access
    input  wire logic        cpu_req,
    input  wire logic        cpu_fetch,
    input  wire logic        cpu_we,
    input  wire logic        cpu_stack,
    input  wire logic [15:0] cpu_addr,
    input  wire logic [7:0]  cpu_wdata,
    output logic      [7:0]  cpu_rdata,
    output logic             cpu_fault,
    // Interrupt vector request
    input  wire logic        irq_req,
    input  wire logic [4:0]  irq_slot,
    output logic             vec_valid,
    output logic      [15:0] vec_addr,
    // Program counter after reset
    output logic      [15:0] boot_pc,
    output logic             boot_done,
    // ROM array
    output logic             rom_rd,
    output logic      [15:0] rom_addr,
    input  wire logic [7:0]  rom_rdata,
    // High-speed RAM array
    output logic             hsram_rd,
    output logic             hsram_wr,
    output logic      [9:0]  hsram_addr,
    output logic             hsram_gpr,
    input  wire logic [7:0]  hsram_rdata,
    // Expansion RAM array
    output logic             xram_rd,
    output logic             xram_wr,
    output logic      [9:0]  xram_addr,
    input  wire logic [7:0]  xram_rdata,
    // Peripheral registers
    output logic             sfr_rd,
    output logic             sfr_wr,
    output logic      [7:0]  sfr_addr,
    input  wire logic [7:0]  sfr_rdata,
    // Shared write data and region tags
    output logic      [7:0]  mem_wdata,
    output logic             in_vector,
    output logic             in_table_call,
    output logic             in_fixed_call
);
    // Map constants must agree with each other and with the offset widths that the strobes carry
    initial begin
        if (ADDR_W != 16) begin
            $error("decoder serves a 16-bit space only");
        end
        if (`HSRAM_TOP - `HSRAM_BASE + 1 != (1 << `RAM_OFS_W)) begin
            $error("high-speed RAM span differs from its offset width");
        end
        if (`XRAM_TOP - `XRAM_BASE + 1 != (1 << `RAM_OFS_W)) begin
            $error("expansion RAM span differs from its offset width");
        end
        if (`GPR_TOP - `GPR_BASE + 1 != (1 << `GPR_OFS_W)) begin
            $error("register bank span differs from its offset width");
        end
        if (`GPR_TOP != `HSRAM_TOP) begin
            $error("register banks must close the high-speed RAM");
        end
        if (`SFR_TOP - `SFR_BASE + 1 != (1 << $bits(sfr_addr))) begin
            $error("peripheral area must span one low address byte");
        end
        if (`HSRAM_TOP >= `SFR_BASE || `ROM_TOP_60K >= `XRAM_BASE) begin
            $error("memory regions overlap");
        end
        if ((`VEC_IRQ_LAST - `VEC_IRQ_FIRST) / 2 + 1 != `IRQ_SLOTS) begin
            $error("interrupt slot count differs from the vector range");
        end
        if (`IRQ_SLOTS > (1 << `IRQ_IDX_W)) begin
            $error("interrupt slot index too narrow");
        end
        if (`XRAM_SEL_PRESENT == `XRAM_SEL_ABSENT) begin
            $error("expansion RAM select codes must differ");
        end
    end

    addr_lookup_if lk ();
    region_classify u_classify (.lk(lk));

    // Boot state and selects
    memmap_pkg::boot_state_t boot_state;
    memmap_pkg::boot_state_t next_boot_state;
    logic [15:0] next_boot_pc;
    logic [7:0]  next_memory_size_select;
    logic [7:0]  next_expansion_ram_size_select;
    logic [15:0] rom_top;
    logic        xram_en;
    logic        booting;
    logic [15:0] addr;
    logic        fetch;
    logic        req;
    logic        wr;
    memmap_pkg::region_t next_rd_region;
    logic [7:0]  next_cpu_rdata;
    logic        next_cpu_fault;
    logic        next_vec_valid;
    logic [15:0] next_vec_addr;

    // Unknown codes fall back to the largest ROM so reset defaults stay usable
    always_comb begin
        unique case (memory_size_select)
            `SIZE_SEL_24K: rom_top = `ROM_TOP_24K; // RL4
            `SIZE_SEL_32K: rom_top = `ROM_TOP_32K; // RL4
            `SIZE_SEL_48K: rom_top = `ROM_TOP_48K; // RL4
            default:       rom_top = `ROM_TOP_60K; // RL4
        endcase
    end

    assign xram_en = (expansion_ram_size_select == `XRAM_SEL_PRESENT); // RL15

    always_comb begin
        next_memory_size_select        = memory_size_select;
        next_expansion_ram_size_select = expansion_ram_size_select;
        if (size_sel_we) begin
            next_memory_size_select = sel_wdata; // RL3
        end
        if (xram_sel_we) begin
            next_expansion_ram_size_select = sel_wdata; // RL3
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            memory_size_select        <= `SIZE_SEL_RESET; // RL2
            expansion_ram_size_select <= `XRAM_SEL_RESET; // RL2
        end else begin
            memory_size_select        <= next_memory_size_select;
            expansion_ram_size_select <= next_expansion_ram_size_select;
        end
    end

    // Boot sequencer reads the reset vector, low byte first
    logic hi_pending;
    logic next_hi_pending;
    logic next_boot_done;

    // CPU requests stay shut out until the whole vector is in boot_pc
    assign booting = !boot_done;

    always_comb begin
        next_boot_state = boot_state;
        next_boot_pc    = boot_pc;
        next_hi_pending = 1'b0;
        next_boot_done  = boot_done | hi_pending;
        unique case (boot_state)
            memmap_pkg::boot_fetch_lo: begin
                next_boot_pc[7:0] = rom_rdata; // RL6
                next_boot_state   = memmap_pkg::boot_fetch_hi;
            end
            memmap_pkg::boot_fetch_hi: begin
                next_boot_pc[15:8] = rom_rdata; // RL6 RL20
                next_hi_pending    = 1'b1;
                next_boot_state    = memmap_pkg::boot_run;
            end
            memmap_pkg::boot_run: begin
                next_boot_state = memmap_pkg::boot_run;
            end
            default: next_boot_state = memmap_pkg::boot_fetch_lo;
        endcase
    end

    // Done trails the high byte by one edge, so boot_pc is whole when it rises
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            boot_state <= memmap_pkg::boot_fetch_lo;
            boot_pc    <= 16'h0000;
            hi_pending <= 1'b0;
            boot_done  <= 1'b0;
        end else begin
            boot_state <= next_boot_state;
            boot_pc    <= next_boot_pc;
            hi_pending <= next_hi_pending;
            boot_done  <= next_boot_done;
        end
    end

    // Address mux: boot reads the single reset vector, shared by all causes
    always_comb begin
        addr  = cpu_addr; // RL1
        fetch = cpu_fetch;
        req   = cpu_req;
        wr    = cpu_we;
        if (booting) begin
            addr  = (boot_state == memmap_pkg::boot_fetch_lo) ?
                    `VEC_RESET : (`VEC_RESET | 16'h0001); // RL7 RL6
            fetch = 1'b0;
            req   = 1'b1;
            wr    = 1'b0;
        end
    end

    assign lk.addr    = addr;
    assign lk.rom_top = rom_top;
    assign lk.xram_en = xram_en;

    // Fetch protection: high-speed RAM and peripherals are data only
    logic fetch_bad;
    logic write_bad;
    logic stack_bad;
    assign fetch_bad = fetch && (lk.region == memmap_pkg::region_hsram ||
                                 lk.region == memmap_pkg::region_sfr); // RL13
    assign write_bad = wr && (lk.region == memmap_pkg::region_rom);
    assign stack_bad = cpu_stack && !booting &&
                       (lk.region != memmap_pkg::region_hsram); // RL14
    logic access_ok;
    assign access_ok = req && !fetch_bad && !write_bad && !stack_bad &&
                       (lk.region != memmap_pkg::region_none);

    always_comb begin
        rom_rd   = access_ok && !wr && lk.region == memmap_pkg::region_rom; // RL19
        rom_addr = addr;
        hsram_rd = access_ok && !wr && lk.region == memmap_pkg::region_hsram; // RL11
        hsram_wr = access_ok && wr && lk.region == memmap_pkg::region_hsram; // RL11
        hsram_addr = 10'(addr - `HSRAM_BASE);
        hsram_gpr  = lk.in_gpr; // RL12
        xram_rd  = access_ok && !wr && lk.region == memmap_pkg::region_xram; // RL16
        xram_wr  = access_ok && wr && lk.region == memmap_pkg::region_xram; // RL16
        xram_addr = 10'(addr - `XRAM_BASE);
        sfr_rd   = access_ok && !wr && lk.region == memmap_pkg::region_sfr; // RL17
        sfr_wr   = access_ok && wr && lk.region == memmap_pkg::region_sfr; // RL17
        sfr_addr = addr[7:0];
        mem_wdata     = cpu_wdata;
        in_vector     = lk.in_vec; // RL5
        in_table_call = lk.in_table_call_instruction; // RL9
        in_fixed_call = lk.in_fixed_area_call_instruction; // RL10
    end

    // Read data is taken from the array that this cycle's request selects,
    // while its address still stands, and shown one cycle later
    always_comb begin
        next_rd_region = access_ok && !wr ? lk.region : memmap_pkg::region_none;
        next_cpu_fault = req && !booting && !access_ok;
        unique case (next_rd_region)
            memmap_pkg::region_rom:   next_cpu_rdata = rom_rdata;
            memmap_pkg::region_hsram: next_cpu_rdata = hsram_rdata;
            memmap_pkg::region_xram:  next_cpu_rdata = xram_rdata;
            memmap_pkg::region_sfr:   next_cpu_rdata = sfr_rdata;
            default:                  next_cpu_rdata = 8'h00;
        endcase
    end

    // Interrupt slot 0 sits at the first maskable vector
    always_comb begin
        next_vec_valid = irq_req && !booting && (irq_slot < 5'(`IRQ_SLOTS)); // RL8
        next_vec_addr  = `VEC_IRQ_FIRST + {10'h000, irq_slot, 1'b0}; // RL8
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cpu_rdata <= 8'h00;
            cpu_fault <= 1'b0;
            vec_valid <= 1'b0;
            vec_addr  <= 16'h0000;
        end else begin
            cpu_rdata <= next_cpu_rdata;
            cpu_fault <= next_cpu_fault;
            vec_valid <= next_vec_valid;
            vec_addr  <= next_vec_addr;
        end
    end
endmodule

// ===== memmap_arrays.sv
// Behavioural memory arrays answering the decoder's strobes
`timescale 1ns/1ps
module memmap_arrays (
    // Strobes and addresses
    input wire logic        rom_rd,
    input wire logic [15:0] rom_addr,
    input wire logic        hsram_rd,
    input wire logic [9:0]  hsram_addr,
    input wire logic        xram_rd,
    input wire logic [9:0]  xram_addr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_addr,
    // Read data
    output logic     [7:0]  rom_rdata,
    output logic     [7:0]  hsram_rdata,
    output logic     [7:0]  xram_rdata,
    output logic     [7:0]  sfr_rdata
);
    // Unselected arrays show inverted data, so a stray sample never matches
    function automatic logic [7:0] pat(input logic [15:0] a, input logic en);
        pat = a[7:0] ^ a[15:8] ^ 8'h5a ^ {8{!en}};
    endfunction

    assign rom_rdata   = pat(rom_addr, rom_rd);
    assign hsram_rdata = pat(16'hfb00 + {6'h0, hsram_addr}, hsram_rd);
    assign xram_rdata  = pat(16'hf400 + {6'h0, xram_addr}, xram_rd);
    assign sfr_rdata   = pat({8'hff, sfr_addr}, sfr_rd);
endmodule

// ===== memmap_cfg.svh
// Address map constants for the CPU memory space decoder
`ifndef MEMMAP_CFG_SVH
`define MEMMAP_CFG_SVH

`define ADDR_W              16
`define SIZE_SEL_RESET      8'hcf
`define XRAM_SEL_RESET      8'h0c
`define SIZE_SEL_24K        8'hc6
`define SIZE_SEL_32K        8'hc8
`define SIZE_SEL_48K        8'hcc
`define SIZE_SEL_60K        8'hcf
`define XRAM_SEL_ABSENT     8'h0c
`define XRAM_SEL_PRESENT    8'h0a
`define ROM_BASE            16'h0000
`define ROM_TOP_24K         16'h5fff
`define ROM_TOP_32K         16'h7fff
`define ROM_TOP_48K         16'hbfff
`define ROM_TOP_60K         16'hefff
`define VEC_BASE            16'h0000
`define VEC_TOP             16'h003f
`define VEC_RESET           16'h0000
`define VEC_IRQ_FIRST       16'h0004
`define VEC_IRQ_LAST        16'h003c
`define IRQ_SLOTS           29
`define IRQ_IDX_W           5
`define TABLE_CALL_INSTRUCTION_BASE          16'h0040
`define TABLE_CALL_INSTRUCTION_TOP           16'h007f
`define FIXED_AREA_CALL_INSTRUCTION_BASE          16'h0800
`define FIXED_AREA_CALL_INSTRUCTION_TOP           16'h0fff
`define XRAM_BASE           16'hf400
`define XRAM_TOP            16'hf7ff
`define HSRAM_BASE          16'hfb00
`define HSRAM_TOP           16'hfeff
`define GPR_BASE            16'hfee0
`define GPR_TOP             16'hfeff
`define SFR_BASE            16'hff00
`define SFR_TOP             16'hffff
`define RAM_OFS_W           10
`define GPR_OFS_W           5

`endif

// ===== memmap_checker.sv
// Port-level assertions for the CPU memory map decoder
`timescale 1ns/1ps
module memmap_checker #(
    parameter int ADDR_W = 16
) (
    // Clock and reset
    input wire logic        clock,
    input wire logic        rst_b,
    // CPU access
    input wire logic        cpu_req,
    input wire logic        cpu_fetch,
    input wire logic        cpu_we,
    input wire logic        cpu_stack,
    input wire logic [15:0] cpu_addr,
    input wire logic        cpu_fault,
    input wire logic        boot_done,
    input wire logic [7:0]  memory_size_select,
    input wire logic [7:0]  expansion_ram_size_select,
    // Vectors
    input wire logic        irq_req,
    input wire logic [4:0]  irq_slot,
    input wire logic        vec_valid,
    input wire logic [15:0] vec_addr,
    // Arrays
    input wire logic        rom_rd,
    input wire logic [15:0] rom_addr,
    input wire logic        hsram_rd,
    input wire logic [9:0]  hsram_addr,
    input wire logic        hsram_gpr,
    input wire logic        sfr_rd,
    input wire logic [7:0]  sfr_addr
);
    logic        go;
    logic        in_hs;
    logic [15:0] hs_ofs;

    assign go     = cpu_req && boot_done;
    assign in_hs  = cpu_addr >= 16'hfb00 && cpu_addr <= 16'hfeff;
    assign hs_ofs = cpu_addr - 16'hfb00;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_b);

    property p_reset_sel;
        $rose(rst_b) |-> memory_size_select == 8'hcf && expansion_ram_size_select == 8'h0c;
    endproperty
    a_reset_sel: assert property (p_reset_sel) else $error("select reset values wrong");

    property p_boot_vec;
        $rose(rst_b) |-> ##[0:2] (rom_rd && rom_addr == 16'h0000) ##1 (rom_rd && rom_addr == 16'h0001);
    endproperty
    a_boot_vec: assert property (p_boot_vec) else $error("boot vector read order wrong");

    property p_vec_addr;
        irq_req && irq_slot < 5'h1d |=> vec_valid && vec_addr == 16'h0004 + {10'h0, $past(irq_slot), 1'b0};
    endproperty
    a_vec_addr: assert property (p_vec_addr) else $error("vector slot address wrong");

    property p_vec_ref;
        irq_req && irq_slot >= 5'h1d |=> !vec_valid;
    endproperty
    a_vec_ref: assert property (p_vec_ref) else $error("vector for missing slot");

    property p_hs_map;
        go && in_hs && !cpu_fetch && !cpu_we |-> hsram_rd && hsram_addr == hs_ofs[9:0] ##1 !cpu_fault;
    endproperty
    a_hs_map: assert property (p_hs_map) else $error("high-speed RAM read misrouted");

    property p_gpr;
        go && in_hs && !cpu_fetch |-> hsram_gpr == (cpu_addr >= 16'hfee0);
    endproperty
    a_gpr: assert property (p_gpr) else $error("register bank flag wrong");

    property p_hs_nofetch;
        go && cpu_fetch && in_hs |=> cpu_fault;
    endproperty
    a_hs_nofetch: assert property (p_hs_nofetch) else $error("fetch from RAM not refused");

    property p_stack;
        go && cpu_stack && !in_hs |=> cpu_fault;
    endproperty
    a_stack: assert property (p_stack) else $error("stack outside RAM not refused");

    property p_sfr;
        go && !cpu_fetch && !cpu_we && !cpu_stack && cpu_addr[15:8] == 8'hff |->
            sfr_rd && sfr_addr == cpu_addr[7:0];
    endproperty
    a_sfr: assert property (p_sfr) else $error("peripheral read misrouted");
endmodule

// ===== memmap_pkg.sv
// Types shared by the memory space decoder
package memmap_pkg;
    typedef enum logic [2:0] {
        region_none  = 3'h0,
        region_rom   = 3'h1,
        region_hsram = 3'h2,
        region_xram  = 3'h3,
        region_sfr   = 3'h4
    } region_t;

    typedef enum logic [1:0] {
        boot_fetch_lo = 2'b00,
        boot_fetch_hi = 2'b01,
        boot_run      = 2'b11
    } boot_state_t;
endpackage

// ===== region_classify.sv
// Combinational classification of one address into a memory region
`timescale 1ns/1ps
`include "memmap_cfg.svh"
module region_classify (
    addr_lookup_if.classifier lk
);
    always_comb begin
        lk.region = memmap_pkg::region_none;
        if (lk.addr >= `SFR_BASE) begin
            lk.region = memmap_pkg::region_sfr; // RL17
        end else if (lk.addr >= `HSRAM_BASE && lk.addr <= `HSRAM_TOP) begin
            lk.region = memmap_pkg::region_hsram; // RL11
        end else if (lk.xram_en && lk.addr >= `XRAM_BASE && lk.addr <= `XRAM_TOP) begin
            lk.region = memmap_pkg::region_xram; // RL15
        end else if (lk.addr <= lk.rom_top) begin
            lk.region = memmap_pkg::region_rom; // RL4
        end
    end

    assign lk.in_vec   = (lk.addr <= `VEC_TOP); // RL5
    assign lk.in_table_call_instruction = (lk.addr >= `TABLE_CALL_INSTRUCTION_BASE) && (lk.addr <= `TABLE_CALL_INSTRUCTION_TOP); // RL9
    assign lk.in_fixed_area_call_instruction = (lk.addr >= `FIXED_AREA_CALL_INSTRUCTION_BASE) && (lk.addr <= `FIXED_AREA_CALL_INSTRUCTION_TOP); // RL10
    assign lk.in_gpr   = (lk.addr >= `GPR_BASE) && (lk.addr <= `GPR_TOP); // RL12
endmodule

// ===== tb_cpu_memory_map_decoder.sv
// Self-checking bench for the CPU memory map decoder
`timescale 1ns/1ps
bind cpu_memory_map_decoder memmap_checker #(.ADDR_W(ADDR_W)) u_chk (.clock, .rst_b, .cpu_req,
    .cpu_fetch, .cpu_we, .cpu_stack, .cpu_addr, .cpu_fault, .boot_done, .memory_size_select,
    .expansion_ram_size_select, .irq_req, .irq_slot, .vec_valid, .vec_addr, .rom_rd, .rom_addr,
    .hsram_rd, .hsram_addr, .hsram_gpr, .sfr_rd, .sfr_addr);
module tb_cpu_memory_map_decoder;
    typedef struct packed {
        logic [2:0]  kind;
        logic [15:0] addr;
        logic        flt;
    } row_t;
    logic        clock, rst_b, size_sel_we, xram_sel_we, cpu_req, cpu_fetch, cpu_we, cpu_stack;
    logic        irq_req, cpu_fault, vec_valid, boot_done, rom_rd, hsram_rd, hsram_wr, hsram_gpr;
    logic        xram_rd, xram_wr, sfr_rd, sfr_wr, in_vector, in_table_call, in_fixed_call;
    logic [4:0]  irq_slot;
    logic [7:0]  sel_wdata, memory_size_select, expansion_ram_size_select, cpu_wdata, cpu_rdata;
    logic [7:0]  rom_rdata, hsram_rdata, xram_rdata, sfr_rdata, sfr_addr, mem_wdata;
    logic [9:0]  hsram_addr, xram_addr;
    logic [15:0] cpu_addr, vec_addr, boot_pc, rom_addr;
    int          fails, n_tests, cycles;
    // Kind bits: fetch, write, stack
    row_t        rows [19] = '{'{3'h0, 16'h0000, 1'h0}, '{3'h0, 16'h003f, 1'h0},
        '{3'h0, 16'h0041, 1'h0}, '{3'h4, 16'h0800, 1'h0}, '{3'h4, 16'h0fff, 1'h0},
        '{3'h0, 16'hefff, 1'h0}, '{3'h0, 16'hf000, 1'h1}, '{3'h2, 16'h0100, 1'h1},
        '{3'h0, 16'hfb00, 1'h0}, '{3'h2, 16'hfeff, 1'h0}, '{3'h4, 16'hfc00, 1'h1},
        '{3'h3, 16'hfd00, 1'h0}, '{3'h1, 16'hfdfe, 1'h0}, '{3'h1, 16'h0100, 1'h1},
        '{3'h0, 16'hff00, 1'h0}, '{3'h4, 16'hff10, 1'h1}, '{3'h0, 16'hf400, 1'h1},
        '{3'h0, 16'hfa00, 1'h1}, '{3'h2, 16'hff10, 1'h0}};
    logic [7:0]  sels [4] = '{8'hc6, 8'hc8, 8'hcc, 8'hcf};
    logic [15:0] tops [4] = '{16'h5fff, 16'h7fff, 16'hbfff, 16'hefff};

    cpu_memory_map_decoder u_dut (.clock, .rst_b, .size_sel_we, .xram_sel_we, .sel_wdata,
        .memory_size_select, .expansion_ram_size_select, .cpu_req, .cpu_fetch, .cpu_we,
        .cpu_stack, .cpu_addr, .cpu_wdata, .cpu_rdata, .cpu_fault, .irq_req, .irq_slot,
        .vec_valid, .vec_addr, .boot_pc, .boot_done, .rom_rd, .rom_addr, .rom_rdata, .hsram_rd,
        .hsram_wr, .hsram_addr, .hsram_gpr, .hsram_rdata, .xram_rd, .xram_wr, .xram_addr,
        .xram_rdata, .sfr_rd, .sfr_wr, .sfr_addr, .sfr_rdata, .mem_wdata, .in_vector,
        .in_table_call, .in_fixed_call);
    memmap_arrays u_mem (.rom_rd, .rom_addr, .hsram_rd, .hsram_addr, .xram_rd, .xram_addr,
        .sfr_rd, .sfr_addr, .rom_rdata, .hsram_rdata, .xram_rdata, .sfr_rdata);

    always #5 clock = ~clock;

    function automatic logic [7:0] pat(input logic [15:0] a);
        pat = a[7:0] ^ a[15:8] ^ 8'h5a;
    endfunction

    task automatic tally_and_finish();
        if (fails == 0 && n_tests > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
            fails++;
        end
    endtask

    // Leaves the request up so rows run back to back
    task automatic acc(input logic [2:0] k, input logic [15:0] a, input logic flt);
        cpu_fetch = k[2];
        cpu_we = k[1];
        cpu_stack = k[0];
        cpu_addr = a;
        cpu_wdata = ~a[7:0];
        cpu_req = 1'b1;
        @(posedge clock);
        #1;
        chk({15'h0, cpu_fault}, {15'h0, flt});
        if (!flt && !k[1]) chk({8'h0, cpu_rdata}, {8'h0, pat(a)});
        if (k[1]) chk({5'h0, sfr_wr, hsram_wr, xram_wr, mem_wdata}, {5'h0, !flt && a >= 16'hff00,
            !flt && a >= 16'hfb00 && a <= 16'hfeff, !flt && a >= 16'hf400 && a <= 16'hf7ff,
            ~a[7:0]});
        chk({13'h0, in_vector, in_table_call, in_fixed_call}, {13'h0, a <= 16'h003f,
            a >= 16'h0040 && a <= 16'h007f, a >= 16'h0800 && a <= 16'h0fff});
    endtask

    task automatic wsel(input logic x, input logic [7:0] v);
        cpu_req = 1'b0;
        size_sel_we = !x;
        xram_sel_we = x;
        sel_wdata = v;
        @(posedge clock);
        #1;
        size_sel_we = 1'b0;
        xram_sel_we = 1'b0;
        chk({8'h0, x ? expansion_ram_size_select : memory_size_select}, {8'h0, v});
    endtask

    task automatic boot();
        rst_b = 1'b1;
        for (int k = 0; k < 10 && boot_done !== 1'b1; k++) begin
            @(posedge clock);
            #1;
        end
        chk({15'h0, boot_done}, 16'h0001);
        chk(boot_pc, {pat(16'h0001), pat(16'h0000)});
        chk({memory_size_select, expansion_ram_size_select}, 16'hcf0c);
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            tally_and_finish();
        end
    end

    initial begin
        {clock, rst_b, size_sel_we, xram_sel_we, cpu_req, cpu_fetch, cpu_we, cpu_stack} = 8'h0;
        {irq_req, irq_slot, sel_wdata, cpu_wdata, cpu_addr} = 38'h0;
        repeat (20) @(posedge clock);
        #1;
        boot();
        foreach (rows[i]) acc(rows[i].kind, rows[i].addr, rows[i].flt);
        for (int v = 0; v < 4; v++) begin
            wsel(1'b0, sels[v]);
            acc(3'h0, tops[v], 1'h0);
            acc(3'h0, tops[v] + 16'h0001, 1'h1);
        end
        wsel(1'b1, 8'h0a);
        acc(3'h0, 16'hf400, 1'h0);
        acc(3'h4, 16'hf7ff, 1'h0);
        acc(3'h2, 16'hf5aa, 1'h0);
        acc(3'h4, 16'hf800, 1'h1);
        cpu_req = 1'b0;
        for (int n = 0; n < 32; n++) begin
            irq_req = 1'b1;
            irq_slot = n[4:0];
            @(posedge clock);
            #1;
            chk({15'h0, vec_valid}, {15'h0, n < 29});
            if (n < 29) chk(vec_addr, 16'h0004 + 16'(2 * n));
        end
        irq_req = 1'b0;
        // Second reset in mid-run, with a request pending
        acc(3'h0, 16'hfb10, 1'h0);
        rst_b = 1'b0;
        #2;
        chk({memory_size_select, expansion_ram_size_select}, 16'hcf0c);
        repeat (2) @(posedge clock);
        #1;
        boot();
        acc(3'h4, 16'hfc00, 1'h1);
        tally_and_finish();
    end
endmodule
